// File: rtl/spi_pin_pkg.sv
package spi_pin_pkg;

	// Data path geometry.
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Serial clock timing produced in master role.
	localparam int CORE_CLK_MHZ = 100;
	localparam int SCK_HALF_NS = 80;
	localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYCLES - 1);
	localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;

	// Reset values of the pin synchronisers and the idle level of the select line.
	localparam logic PIN_RESET = 1'b0;
	localparam logic SELECT_IDLE = 1'b1;

	typedef enum logic [1:0] {
		MST_IDLE,
		MST_LOW,
		MST_HIGH
	} mst_state_t;

endpackage

// File: rtl/byte_fifo_if.sv
`timescale 1ns/100ps
interface byte_fifo_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] in_data;
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] out_data;
	logic out_valid;
	logic out_ready;

	modport filler (output in_data, output in_valid, input in_ready);
	modport store (input in_data, input in_valid, output in_ready,
		output out_data, output out_valid, input out_ready);
	modport drainer (input out_data, input out_valid, output out_ready);
endinterface

// File: rtl/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Both faces of the buffer.
	byte_fifo_if.store port
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr;
		logic [PTR_W-1:0] rd;
		logic [CNT_W-1:0] count;
	} fifo_state_t;

	fifo_state_t r;
	fifo_state_t next_r;
	logic do_push;
	logic do_pop;

	// Full and empty come straight from the occupancy count.
	assign port.in_ready = (r.count != CNT_FULL);
	assign port.out_valid = (r.count != '0);
	assign port.out_data = r.mem[r.rd];
	assign do_push = port.in_valid & port.in_ready;
	assign do_pop = port.out_valid & port.out_ready;

	// Pointers wrap explicitly so a depth that is not a power of two still works.
	always_comb begin
		next_r = r;
		if (do_push) begin
			next_r.mem[r.wr] = port.in_data;
			next_r.wr = (r.wr == PTR_LAST) ? '0 : r.wr + 1'b1;
		end
		if (do_pop) begin
			next_r.rd = (r.rd == PTR_LAST) ? '0 : r.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_r.count = r.count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_r.count = r.count - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

// File: rtl/spi_pin_modes.sv
// Functional notes
// - Enabled with role select high, the port is master and in normal mode sends on MOSI and receives on MISO.
// - As a bidirectional master only MOSI carries data and MISO is left alone unless a mode fault occurs.
// - In bidirectional mode the shared pin drives shift data when its output enable is set and always feeds the shift input.
// - The serial clock pin is driven in master role and only read in slave role.
// - Slave select may be driven as master but is always an input as slave.
// - Bidirectional mode does not change how serial clock and slave select behave.
// - The mode fault is the only error this block reports.
// - As master with fault detection on, a low slave select sets the fault flag.
// - A mode fault drops the port into slave role, so a bidirectional port moves onto MISO.
// - As master with fault detection off, slave select is ignored and the fault flag stays clear.
`timescale 1ns/100ps
module spi_pin_modes (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Control bits.
	input wire logic i_port_enable_bit,
	input wire logic i_role_select,
	input wire logic i_pin_config_bit,
	input wire logic i_shared_pin_output_enable,
	input wire logic i_fault_detect_enable,
	input wire logic i_select_output_enable,
	input wire logic i_fault_clear,
	// Status bits.
	output logic o_fault_flag,
	output logic o_master_active,
	// Transmit byte handshake.
	input wire logic [spi_pin_pkg::DATA_W-1:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	// Received byte stream out of the buffer.
	output logic [spi_pin_pkg::DATA_W-1:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	// MOSI pin.
	input wire logic i_mosi,
	output logic o_mosi,
	output logic o_mosi_oe,
	// MISO pin.
	input wire logic i_miso,
	output logic o_miso,
	output logic o_miso_oe,
	// Serial clock pin.
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	// Slave select pin, active low on the wire.
	input wire logic i_select_n,
	output logic o_select_n,
	output logic o_select_n_oe
);
	import spi_pin_pkg::*;

	typedef struct packed {
		logic mosi_s1;
		logic mosi_s2;
		logic miso_s1;
		logic miso_s2;
		logic sck_s1;
		logic sck_s2;
		logic sck_d;
		logic sel_s1;
		logic sel_s2;
		logic sel_d;
		logic fault;
		mst_state_t mst;
		logic [DIV_W-1:0] div;
		logic [2:0] bit_cnt;
		logic [DATA_W-1:0] shift;
		logic [DATA_W-1:0] rx;
		logic sck_out;
		logic push;
		logic [DATA_W-1:0] push_data;
	} pin_state_t;

	localparam pin_state_t STATE_RESET = '{
		mosi_s1: PIN_RESET, mosi_s2: PIN_RESET, miso_s1: PIN_RESET, miso_s2: PIN_RESET,
		sck_s1: PIN_RESET, sck_s2: PIN_RESET, sck_d: PIN_RESET,
		sel_s1: SELECT_IDLE, sel_s2: SELECT_IDLE, sel_d: SELECT_IDLE,
		fault: 1'b0, mst: MST_IDLE, div: DIV_RESET, bit_cnt: 3'h0,
		shift: 8'h00, rx: 8'h00, sck_out: 1'b0, push: 1'b0, push_data: 8'h00
	};

	pin_state_t r;
	pin_state_t next_r;
	logic master_req;
	logic master;
	logic slave;
	logic fault_set;
	logic serial_in;
	logic sel_fall;
	logic sck_rise;
	logic sck_fall;
	logic selected;
	logic mst_start;

	byte_fifo_if #(.WIDTH(DATA_W)) rx_path ();

	// Role resolution: a latched fault overrides the role select.
	assign master_req = i_port_enable_bit & i_role_select;
	assign master = master_req & ~r.fault;
	assign slave = i_port_enable_bit & ~master;

	// Only a low select seen while master with detection on is an error; nothing else is flagged.
	assign fault_set = master & i_fault_detect_enable & ~r.sel_s2;

	// Pick the serial input pin from role and pin mode.
	always_comb begin
		if (i_pin_config_bit) begin
			serial_in = master ? r.mosi_s2 : r.miso_s2;
		end else begin
			serial_in = master ? r.miso_s2 : r.mosi_s2;
		end
	end

	// Edges of the synchronised link clock and select line.
	assign sel_fall = r.sel_d & ~r.sel_s2;
	assign sck_rise = r.sck_s2 & ~r.sck_d;
	assign sck_fall = r.sck_d & ~r.sck_s2;
	assign selected = slave & ~r.sel_s2;
	assign mst_start = i_tx_valid & o_tx_ready & master;

	// A master only starts when the buffer has room, so its byte is never dropped.
	assign o_tx_ready = (master & (r.mst == MST_IDLE) & rx_path.in_ready & ~r.push)
		| (slave & sel_fall);

	always_comb begin
		next_r = r;
		// Two flip-flops on every pin before any logic looks at it.
		next_r.mosi_s1 = i_mosi;
		next_r.mosi_s2 = r.mosi_s1;
		next_r.miso_s1 = i_miso;
		next_r.miso_s2 = r.miso_s1;
		next_r.sck_s1 = i_sck;
		next_r.sck_s2 = r.sck_s1;
		next_r.sck_d = r.sck_s2;
		next_r.sel_s1 = i_select_n;
		next_r.sel_s2 = r.sel_s1;
		next_r.sel_d = r.sel_s2;
		next_r.push = 1'b0;

		// Set wins over the software clear; detection off as master holds the flag clear.
		if (fault_set) begin
			next_r.fault = 1'b1;
		end else if (i_fault_clear || (master_req && !i_fault_detect_enable)) begin
			next_r.fault = 1'b0;
		end

		if (master) begin
			case (r.mst)
				MST_IDLE: begin
					next_r.sck_out = 1'b0;
					if (mst_start) begin
						next_r.shift = i_tx_data;
						next_r.bit_cnt = 3'h0;
						next_r.div = DIV_RESET;
						next_r.mst = MST_LOW;
					end
				end
				MST_LOW: begin
					next_r.div = r.div + 1'b1;
					if (r.div == DIV_LAST) begin
						next_r.div = DIV_RESET;
						next_r.sck_out = 1'b1;
						next_r.rx = {r.rx[DATA_W-2:0], serial_in};
						next_r.mst = MST_HIGH;
					end
				end
				MST_HIGH: begin
					next_r.div = r.div + 1'b1;
					if (r.div == DIV_LAST) begin
						next_r.div = DIV_RESET;
						next_r.sck_out = 1'b0;
						if (r.bit_cnt == BIT_LAST) begin
							next_r.push = 1'b1;
							next_r.push_data = r.rx;
							next_r.mst = MST_IDLE;
						end else begin
							next_r.shift = {r.shift[DATA_W-2:0], 1'b0};
							next_r.bit_cnt = r.bit_cnt + 1'b1;
							next_r.mst = MST_LOW;
						end
					end
				end
				default: begin
					next_r.mst = MST_IDLE;
				end
			endcase
		end else begin
			// Losing master role aborts any byte in flight.
			next_r.mst = MST_IDLE;
			next_r.sck_out = 1'b0;
			next_r.div = DIV_RESET;
			if (!selected) begin
				next_r.bit_cnt = 3'h0;
			end
			if (slave && sel_fall) begin
				next_r.shift = i_tx_valid ? i_tx_data : 8'h00;
				next_r.bit_cnt = 3'h0;
			end else if (selected && sck_rise) begin
				next_r.rx = {r.rx[DATA_W-2:0], serial_in};
				// A slave cannot stall its master; a byte that meets a full buffer is lost.
				if (r.bit_cnt == BIT_LAST && rx_path.in_ready) begin
					next_r.push = 1'b1;
					next_r.push_data = {r.rx[DATA_W-2:0], serial_in};
				end
			end else if (selected && sck_fall) begin
				next_r.shift = {r.shift[DATA_W-2:0], 1'b0};
				next_r.bit_cnt = r.bit_cnt + 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			r <= STATE_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Received bytes queue here until the user drains them.
	byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_buffer (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.port(rx_path.store)
	);

	assign rx_path.in_valid = r.push;
	assign rx_path.in_data = r.push_data;
	assign rx_path.out_ready = i_rx_ready;
	assign o_rx_data = rx_path.out_data;
	assign o_rx_valid = rx_path.out_valid;

	// Data pin drivers; both carry the shift register's top bit.
	assign o_mosi = r.shift[DATA_W-1];
	assign o_miso = r.shift[DATA_W-1];
	always_comb begin
		o_mosi_oe = 1'b0;
		o_miso_oe = 1'b0;
		if (i_pin_config_bit) begin
			o_mosi_oe = master & i_shared_pin_output_enable;
			o_miso_oe = selected & i_shared_pin_output_enable;
		end else begin
			o_mosi_oe = master;
			o_miso_oe = selected;
		end
	end

	// Clock and select directions ignore the pin mode entirely.
	assign o_sck = r.sck_out;
	assign o_sck_oe = master;
	assign o_select_n = (r.mst == MST_IDLE);
	// Driving select is only allowed with detection off, so our own drive never faults us.
	assign o_select_n_oe = master & i_select_output_enable & ~i_fault_detect_enable;

	// Status.
	assign o_fault_flag = r.fault;
	assign o_master_active = master;
endmodule

// File: verif/spi_pin_modes_sva.sv
`timescale 1ns/100ps
module spi_pin_modes_sva (
	// Clock, reset and controls.
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_port_enable_bit,
	input wire logic i_role_select,
	input wire logic i_pin_config_bit,
	input wire logic i_shared_pin_output_enable,
	input wire logic i_fault_detect_enable,
	input wire logic i_fault_clear,
	input wire logic i_select_n,
	// Watched outputs.
	input wire logic o_fault_flag,
	input wire logic o_master_active,
	input wire logic o_mosi_oe,
	input wire logic o_miso_oe,
	input wire logic o_sck,
	input wire logic o_sck_oe,
	input wire logic o_select_n_oe
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	// Master request, before any fault takes it away.
	wire logic req = i_port_enable_bit && i_role_select;
	// Select must stay low long enough to cross the synchronisers.
	sequence sel_low_held;
		(req && i_fault_detect_enable && !i_select_n && !i_fault_clear) [*4];
	endsequence
	sequence sck_rise;
		o_master_active && $rose(o_sck);
	endsequence
	role_a: assert property (o_master_active == (req && !o_fault_flag))
		else $error("bad role");
	sck_dir_a: assert property (o_sck_oe == o_master_active)
		else $error("bad clock direction");
	select_dir_a: assert property (!o_master_active |-> !o_select_n_oe)
		else $error("select driven as slave");
	fault_set_a: assert property (sel_low_held |-> ##[0:2] o_fault_flag)
		else $error("fault flag not set");
	fault_off_a: assert property (req && !i_fault_detect_enable |=> !o_fault_flag)
		else $error("fault flag with detect off");
	fault_cause_a: assert property ($rose(o_fault_flag) |-> $past(i_fault_detect_enable))
		else $error("fault flag without cause");
	fault_slave_a: assert property (o_fault_flag |-> !o_master_active && !o_sck_oe)
		else $error("master kept after fault");
	bidir_master_a: assert property (o_master_active && i_pin_config_bit |->
		o_mosi_oe == i_shared_pin_output_enable && !o_miso_oe) else $error("bad bidir master");
	bidir_slave_a: assert property (i_port_enable_bit && i_pin_config_bit && !req |->
		!o_mosi_oe && !(o_miso_oe && !i_shared_pin_output_enable)) else $error("bad bidir slave");
	sck_half_a: assert property (sck_rise |-> (o_sck [*8]) or (##[1:8] !o_master_active))
		else $error("bad clock half period");
endmodule
bind spi_pin_modes spi_pin_modes_sva u_spi_pin_modes_sva (
	.i_core_clk(i_core_clk),
	.i_reset(i_reset),
	.i_port_enable_bit(i_port_enable_bit),
	.i_role_select(i_role_select),
	.i_pin_config_bit(i_pin_config_bit),
	.i_shared_pin_output_enable(i_shared_pin_output_enable),
	.i_fault_detect_enable(i_fault_detect_enable),
	.i_fault_clear(i_fault_clear),
	.i_select_n(i_select_n),
	.o_fault_flag(o_fault_flag),
	.o_master_active(o_master_active),
	.o_mosi_oe(o_mosi_oe),
	.o_miso_oe(o_miso_oe),
	.o_sck(o_sck),
	.o_sck_oe(o_sck_oe),
	.o_select_n_oe(o_select_n_oe)
);

// File: verif/spi_far_slave.sv
`timescale 1ns/100ps
module spi_far_slave (
	// Wires as seen on the bus.
	input wire logic i_sck,
	input wire logic i_select_n,
	input wire logic i_mosi,
	// Reply line and what was heard.
	output logic o_miso = 1'b0,
	output logic [7:0] o_got,
	output int o_count = 0
);
	logic [7:0] tx, rx;
	// Only the reply line is ever driven, never clock, data out or select.
	always @(negedge i_select_n) begin
		tx = 8'hC3 ^ 8'(o_count);
		o_miso = tx[7];
	end
	// Capture on the rise, next bit on the fall, most significant first.
	always @(posedge i_sck) begin
		if (!i_select_n) begin
			rx = {rx[6:0], i_mosi};
		end
	end
	always @(negedge i_sck) begin
		if (!i_select_n) begin
			tx = {tx[6:0], 1'b0};
			o_miso = tx[7];
		end
	end
	// Released line shows the inverse, so a stale bit never passes for data.
	always @(posedge i_select_n) begin
		o_got = rx;
		o_count = o_count + 1;
		o_miso = ~o_miso;
	end
endmodule

// File: verif/spi_pin_modes_bench.sv
`timescale 1ns/100ps
module spi_pin_modes_bench;
	import spi_pin_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_port_enable_bit = 1'b1;
	logic i_role_select = 1'b1;
	logic i_pin_config_bit = 1'b0;
	logic i_shared_pin_output_enable = 1'b0;
	logic i_fault_detect_enable = 1'b0;
	logic i_select_output_enable = 1'b1;
	logic i_fault_clear = 1'b0;
	logic i_tx_valid = 1'b0;
	logic i_rx_ready = 1'b0;
	logic [DATA_W-1:0] i_tx_data = 8'h00;
	logic [DATA_W-1:0] o_rx_data, m_got, got;
	logic o_fault_flag, o_master_active, o_tx_ready, o_rx_valid, m_miso;
	logic o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_sck, o_sck_oe, o_select_n, o_select_n_oe;
	logic sck_d = 1'b0, sel_d = 1'b1, mosi_d = 1'b0;
	int err_count = 0, n_tests = 0, cyc = 0, m_cnt, base, cnt;
	// Each wire follows whoever enables it; select idles high by its pull-up.
	wire logic i_mosi = o_mosi_oe ? o_mosi : mosi_d;
	wire logic i_miso = o_miso_oe ? o_miso : m_miso;
	wire logic i_sck = o_sck_oe ? o_sck : sck_d;
	wire logic i_select_n = o_select_n_oe ? o_select_n : sel_d;
	spi_pin_modes u_spi_pin_modes (
		.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_port_enable_bit(i_port_enable_bit), .i_role_select(i_role_select),
		.i_pin_config_bit(i_pin_config_bit),
		.i_shared_pin_output_enable(i_shared_pin_output_enable),
		.i_fault_detect_enable(i_fault_detect_enable),
		.i_select_output_enable(i_select_output_enable), .i_fault_clear(i_fault_clear),
		.o_fault_flag(o_fault_flag), .o_master_active(o_master_active),
		.i_tx_data(i_tx_data), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
		.o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_rx_ready(i_rx_ready),
		.i_mosi(i_mosi), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
		.i_miso(i_miso), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
		.i_sck(i_sck), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
		.i_select_n(i_select_n), .o_select_n(o_select_n), .o_select_n_oe(o_select_n_oe)
	);
	spi_far_slave u_spi_far_slave (.i_sck(i_sck), .i_select_n(i_select_n), .i_mosi(i_mosi),
		.o_miso(m_miso), .o_got(m_got), .o_count(m_cnt));
	initial forever #5 i_core_clk = ~i_core_clk;
	task automatic summarize();
		$display("tests=%0d errors=%0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Master byte: offer it until taken, then wait for the frame to close.
	task automatic send(input logic [7:0] b);
		cnt = m_cnt;
		i_tx_data <= b;
		i_tx_valid <= 1'b1;
		do @(negedge i_core_clk); while (o_tx_ready !== 1'b1);
		@(posedge i_core_clk);
		i_tx_valid <= 1'b0;
		while (m_cnt == cnt) @(posedge i_core_clk);
	endtask
	// Slave byte at a 160 ns link clock driven from this side.
	task automatic slave_xfer(input logic [7:0] b, input logic [7:0] reply);
		i_tx_data <= reply;
		i_tx_valid <= 1'b1;
		sel_d <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_tx_valid <= 1'b0;
		for (int k = 7; k >= 0; k--) begin
			mosi_d <= b[k];
			repeat (8) @(posedge i_core_clk);
			sck_d <= 1'b1;
			got[k] = i_miso;
			repeat (8) @(posedge i_core_clk);
			sck_d <= 1'b0;
		end
		repeat (8) @(posedge i_core_clk);
		sel_d <= 1'b1;
		repeat (4) @(posedge i_core_clk);
	endtask
	// The head is read mid-cycle, since a push on the edge just gone only settles after it.
	task automatic pop(input logic [7:0] e);
		@(negedge i_core_clk);
		chk({7'h00, o_rx_valid}, 8'h01);
		chk(o_rx_data, e);
		@(posedge i_core_clk);
		i_rx_ready <= 1'b1;
		@(posedge i_core_clk);
		i_rx_ready <= 1'b0;
		@(posedge i_core_clk);
	endtask
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_reset <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		base = m_cnt;
		// Fill the buffer while the reader stalls, then see it refuse.
		for (int k = 0; k < 8; k++) begin
			send(8'h10 + 8'(k));
			chk(m_got, 8'h10 + 8'(k));
		end
		repeat (20) @(posedge i_core_clk);
		chk({7'h00, o_tx_ready}, 8'h00);
		chk({6'h00, o_select_n, o_sck}, 8'h02);
		for (int k = 0; k < 8; k++) pop(8'hC3 ^ 8'(base + k));
		chk({7'h00, o_rx_valid}, 8'h00);
		// Bidirectional master hears its own shared pin.
		i_pin_config_bit <= 1'b1;
		i_shared_pin_output_enable <= 1'b1;
		send(8'h5A);
		chk(m_got, 8'h5A);
		pop(8'h5A);
		i_role_select <= 1'b0;
		slave_xfer(8'h00, 8'hE1);
		chk(got, 8'hE1);
		pop(8'hE1);
		i_pin_config_bit <= 1'b0;
		slave_xfer(8'h69, 8'h96);
		chk(got, 8'h96);
		pop(8'h69);
		// Another master pulls select low while detection is on.
		i_pin_config_bit <= 1'b1;
		i_role_select <= 1'b1;
		i_select_output_enable <= 1'b0;
		i_fault_detect_enable <= 1'b1;
		sel_d <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		chk({6'h00, o_fault_flag, o_master_active}, 8'h02);
		chk({6'h00, o_mosi_oe, o_miso_oe}, 8'h01);
		sel_d <= 1'b1;
		i_fault_clear <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		i_fault_clear <= 1'b0;
		i_fault_detect_enable <= 1'b0;
		sel_d <= 1'b0;
		repeat (6) @(posedge i_core_clk);
		chk({6'h00, o_fault_flag, o_master_active}, 8'h01);
		i_port_enable_bit <= 1'b0;
		@(posedge i_core_clk);
		chk({4'h0, o_mosi_oe, o_miso_oe, o_sck_oe, o_select_n_oe}, 8'h00);
		summarize();
	end
	// Cuts a hang short well past the expected run length.
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
endmodule
